// ---- design/cw_bank.sv ----
// control-word bank: register words and paged buffer words behind AXI4-Lite
// assumes a single clock; host software programs the words per its recommendations
`timescale 1ns/10ps
module cw_bank #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // axi write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // decoded settings
    output cw_bank_pkg::cw_settings_s o_settings
);

    logic [3:0] reg_word_q [cw_bank_pkg::WORD_COUNT];
    logic [3:0] buf_word_q [cw_bank_pkg::PAGE_COUNT][cw_bank_pkg::WORD_COUNT];
    logic [3:0] page_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic wr_reg_hit;
    logic wr_buf_hit;
    logic wr_page_hit;
    logic [3:0] wr_idx;
    logic [3:0] rd_word;
    logic rd_ok;
    logic [3:0] rd_idx;
    logic aw_held_d;
    logic w_held_d;
    logic bvalid_d;
    logic rvalid_d;
    logic wr_strb;
    logic wr_reg_en;
    logic wr_buf_en;
    logic wr_page_en;

    // write channels are taken in either order and held until both are here
    assign wa = aw_held_q ? awaddr_q : i_awaddr;
    assign wd = w_held_q ? wdata_q : i_wdata;
    assign wr_go = (aw_held_q | (i_awvalid & o_awready)) & (w_held_q | (i_wvalid & o_wready)) & ~o_bvalid;
    assign wr_idx = wa[5:2];
    assign wr_reg_hit = (wa[11:6] == cw_bank_pkg::REG_SPACE_BASE[11:6]);
    assign wr_buf_hit = (wa[11:6] == cw_bank_pkg::BUF_SPACE_BASE[11:6]);
    // page select lives in word 7 of every page, so any page reaches it
    assign wr_page_hit = wr_buf_hit & (wr_idx == cw_bank_pkg::IDX_PAGE_SEL);

    // lane 0 carries the whole word; its strobe comes with the data channel, held or live
    assign wr_strb = w_held_q ? wstrb_q[0] : i_wstrb[0];
    assign wr_reg_en = wr_go & wr_reg_hit & wr_strb;
    assign wr_buf_en = wr_go & wr_buf_hit & ~wr_page_hit & wr_strb;
    assign wr_page_en = wr_go & wr_page_hit & wr_strb;

    // next values of the channel flags, so that every ready output can come from a flop
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        bvalid_d = o_bvalid;
        rvalid_d = o_rvalid;
        if (wr_go) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
        end else begin
            if (i_awvalid & o_awready) begin
                aw_held_d = 1'b1;
            end
            if (i_wvalid & o_wready) begin
                w_held_d = 1'b1;
            end
            if (i_bready) begin
                bvalid_d = 1'b0;
            end
        end
        if (i_arvalid & o_arready) begin
            rvalid_d = 1'b1;
        end else if (i_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // ready flops: a channel is refused while it is held or its answer is pending
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_arready <= 1'b1;
        end else begin
            o_awready <= ~aw_held_d & ~bvalid_d;
            o_wready <= ~w_held_d & ~bvalid_d;
            o_arready <= ~rvalid_d;
        end
    end

    // hold a channel that arrived alone
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (i_awvalid & o_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid & o_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
        end
    end

    // write response, error on unmapped address
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bvalid <= 1'b0;
            o_bresp <= cw_bank_pkg::RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= (wr_reg_hit | wr_buf_hit) ? cw_bank_pkg::RESP_OKAY : cw_bank_pkg::RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // register words: 4 bits each, reserved bits dropped, one flop group per word
    for (genvar g = 0; g < cw_bank_pkg::WORD_COUNT; g++) begin : g_reg_word
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                reg_word_q[g] <= cw_bank_pkg::WORD_RESET;
            end else if (wr_reg_en && (wr_idx == 4'(g))) begin
                reg_word_q[g] <= wd[3:0] & cw_bank_pkg::REG_MASK[g];
            end
        end
    end

    // buffer words of the selected page
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int p = 0; p < cw_bank_pkg::PAGE_COUNT; p++) begin
                for (int i = 0; i < cw_bank_pkg::WORD_COUNT; i++) begin
                    buf_word_q[p][i] <= cw_bank_pkg::WORD_RESET;
                end
            end
        end else if (wr_buf_en) begin
            if (page_q == 4'h0) begin
                buf_word_q[0][wr_idx] <= wd[3:0] & cw_bank_pkg::BUF0_MASK[wr_idx];
            end else if (page_q == 4'h1) begin
                // function 1 words other than word 0 lie outside this bank
                if (wr_idx == cw_bank_pkg::IDX_CS_TERM) begin
                    buf_word_q[1][wr_idx] <= wd[3:0];
                end
            end
        end
    end

    // page selector
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            page_q <= cw_bank_pkg::PAGE_RESET;
        end else if (wr_page_en) begin
            page_q <= wd[3:0];
        end
    end

    // read decode
    assign rd_idx = i_araddr[5:2];
    always_comb begin
        rd_word = 4'h0;
        rd_ok = 1'b1;
        if (i_araddr[11:6] == cw_bank_pkg::REG_SPACE_BASE[11:6]) begin
            rd_word = reg_word_q[rd_idx];
        end else if (i_araddr[11:6] == cw_bank_pkg::BUF_SPACE_BASE[11:6]) begin
            if (rd_idx == cw_bank_pkg::IDX_PAGE_SEL) begin
                rd_word = page_q;
            end else if (page_q == 4'h0) begin
                rd_word = buf_word_q[0][rd_idx];
            end else if (page_q == 4'h1 && rd_idx == cw_bank_pkg::IDX_CS_TERM) begin
                rd_word = buf_word_q[1][rd_idx];
            end else begin
                rd_word = 4'h0;
            end
        end else if (i_araddr == cw_bank_pkg::STATUS_ADDR[ADDR_W-1:0]) begin
            rd_word = {3'h0, o_settings.training_reserved};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // read channel, one cycle answer
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= cw_bank_pkg::RESP_OKAY;
        end else if (i_arvalid & o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= {28'h000_0000, rd_word};
            o_rresp <= rd_ok ? cw_bank_pkg::RESP_OKAY : cw_bank_pkg::RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // decoded settings registered toward the module logic
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_settings <= '0;
        end else begin
            o_settings.input_termination_code <= {reg_word_q[cw_bank_pkg::IDX_REG_TERM_HIGH][2:0],
                reg_word_q[cw_bank_pkg::IDX_REG_TERM_LOW][2]};
            o_settings.swap_mode_bit <= reg_word_q[cw_bank_pkg::IDX_REG_TERM_HIGH][3];
            o_settings.select_termination <= buf_word_q[1][cw_bank_pkg::IDX_CS_TERM][2:0];
            o_settings.upper_select_termination <= buf_word_q[1][cw_bank_pkg::IDX_CS_TERM][3];
            // reserved training codes fall back to normal operation
            if (buf_word_q[0][cw_bank_pkg::IDX_TRAINING][2:0] > cw_bank_pkg::TRAIN_MEM) begin
                o_settings.training_mode_field <= cw_bank_pkg::TRAIN_NORMAL;
                o_settings.training_reserved <= 1'b1;
            end else begin
                o_settings.training_mode_field <= buf_word_q[0][cw_bank_pkg::IDX_TRAINING][2:0];
                o_settings.training_reserved <= 1'b0;
            end
            o_settings.page_select <= page_q;
        end
    end

endmodule // cw_bank

// ---- design/cw_bank_pkg.sv ----
// constants and carried types for the control-word bank
// assumes a single 50 MHz clock domain and an AXI4-Lite master outside
//
// How it works
// - word 7 of any function page holds the page selector for later accesses
// - buffer word 12 training field picks normal, write leveling or memory training
// - register word 8 bits 2:0 hold upper termination bits; bit 3 swap mode
// - full termination code is word 8 bits 2:0 above word 2 bit 2
// - function 1 word 0 drives chip-select termination; top bit picks upper selects
// - register words 6, 7, 12 to 15 are fully reserved and inert
package cw_bank_pkg;

    // word spaces selected by address bits
    localparam logic [11:0] REG_SPACE_BASE = 12'h000;
    localparam logic [11:0] BUF_SPACE_BASE = 12'h040;
    localparam logic [11:0] STATUS_ADDR = 12'h100;
    localparam int WORD_COUNT = 16;
    localparam int PAGE_COUNT = 2;

    // word indices
    localparam logic [3:0] IDX_REG_TERM_LOW = 4'h2;
    localparam logic [3:0] IDX_PAGE_SEL = 4'h7;
    localparam logic [3:0] IDX_REG_TERM_HIGH = 4'h8;
    localparam logic [3:0] IDX_TRAINING = 4'hC;
    localparam logic [3:0] IDX_CS_TERM = 4'h0;

    // reserved-bit masks per register word and per page 0 buffer word (1 = implemented)
    localparam logic [15:0][3:0] REG_MASK = {
        4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'h7, 4'hD, 4'hF,
        4'h0, 4'h0, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
    localparam logic [15:0][3:0] BUF0_MASK = {
        4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'h7, 4'hE, 4'hF,
        4'hF, 4'h7, 4'hF, 4'hF, 4'hF, 4'hB, 4'hF, 4'hF};

    // value after reset of every word
    localparam logic [3:0] WORD_RESET = 4'h0;
    localparam logic [3:0] PAGE_RESET = 4'h0;

    // training codes
    typedef enum logic [2:0] {
        TRAIN_NORMAL = 3'h0,
        TRAIN_HOST_WL = 3'h1,
        TRAIN_MEM = 3'h2
    } training_mode_field_e;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // decoded settings that leave the block
    typedef struct packed {
        logic [3:0] input_termination_code;
        logic swap_mode_bit;
        logic [2:0] select_termination;
        logic upper_select_termination;
        logic [2:0] training_mode_field;
        logic training_reserved;
        logic [3:0] page_select;
    } cw_settings_s;

endpackage

// ---- verif/cw_bank_props.sv ----
// assertions on the control-word bank ports
// assumes one clock domain and a bind onto every cw_bank instance
`timescale 1ns/10ps
module cw_bank_props (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // bus handshake and answers
    input wire logic o_awready,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    // decoded settings
    input wire cw_bank_pkg::cw_settings_s o_settings
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    a_wresp_holds:
    assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
    a_rresp_holds:
    assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp)) else $error("read moved");
    a_read_answer:
    assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
    a_upper_read_zero:
    assert property (o_rvalid |-> o_rdata[31:4] == 28'h0) else $error("upper read bits set");
    a_write_busy:
    assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken while answering");
    a_read_busy:
    assert property (o_rvalid |-> !o_arready) else $error("read taken while answering");
    a_train_reserved_normal:
    assert property (o_settings.training_reserved |-> o_settings.training_mode_field == 3'h0) else $error("bad mode");
    a_train_code_legal:
    assert property (o_settings.training_mode_field < 3'h3) else $error("reserved training code driven");
    a_settings_after_write:
    assert property ($changed(o_settings) |-> o_bvalid || $past(o_bvalid)) else $error("settings moved alone");
    c_read: cover property (o_rvalid && i_rready);
    c_write_error: cover property (o_bvalid && o_bresp == cw_bank_pkg::RESP_SLVERR);
    c_train_reserved: cover property (o_settings.training_reserved);
endmodule // cw_bank_props
bind cw_bank cw_bank_props u_props (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .o_awready(o_awready),
    .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_settings(o_settings));

// ---- verif/host_axi_master.sv ----
// host model: programs control words over AXI4-Lite, one write and one read at a time
// assumes the slave answers within 64 cycles; a longer wait raises o_hang
`timescale 1ns/10ps
module host_axi_master (
    // clock
    input wire logic i_sys_clk,
    // write channels
    output logic o_awvalid,
    input wire logic i_awready,
    output logic [11:0] o_awaddr,
    output logic o_wvalid,
    input wire logic i_wready,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    input wire logic i_bvalid,
    output logic o_bready,
    // read channels
    output logic o_arvalid,
    input wire logic i_arready,
    output logic [11:0] o_araddr,
    input wire logic i_rvalid,
    output logic o_rready,
    // wait ran out
    output logic o_hang
);
    // idle bus at time zero
    initial {o_awvalid, o_awaddr, o_wvalid, o_wdata, o_wstrb, o_bready, o_arvalid, o_araddr, o_rready, o_hang} = '0;
    // address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge i_sys_clk);
        o_awaddr <= a;
        o_wdata <= d;
        o_wstrb <= s;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge i_sys_clk);
            if (o_awvalid && i_awready) o_awvalid <= 1'b0;
            if (o_wvalid && i_wready) o_wvalid <= 1'b0;
            if (i_bvalid) break;
        end
        o_bready <= 1'b0;
        if (n == 64) o_hang <= 1'b1;
    endtask
    // read request held until taken, rready held until the answer
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge i_sys_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge i_sys_clk);
            if (o_arvalid && i_arready) o_arvalid <= 1'b0;
            if (i_rvalid) break;
        end
        o_rready <= 1'b0;
        if (n == 64) o_hang <= 1'b1;
    endtask
endmodule // host_axi_master

// ---- verif/test_cw_bank.sv ----
// self-checking bench for the control-word bank
// assumes the host model drives the bus and a monitor compares answers in order
`timescale 1ns/10ps
module test_cw_bank;
    logic i_sys_clk, i_arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, hang;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    cw_bank_pkg::cw_settings_s settings, e;
    int n_checks, miscompares;
    logic [31:0] exp_rd[$];
    logic [1:0] exp_rr[$], exp_br[$];
    // host programming in its recommended form
    logic [11:0] pa [12] = '{12'h024, 12'h028, 12'h02C, 12'h020, 12'h008, 12'h040, 12'h064,
        12'h06C, 12'h074, 12'h078, 12'h07C, 12'h070};
    logic [3:0] pd [12] = '{4'hD, 4'h3, 4'h1, 4'h3, 4'h4, 4'h2, 4'hC, 4'h9, 4'h9, 4'hE, 4'h3, 4'h0};
    cw_bank uut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
        .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .o_settings(settings));
    host_axi_master host (.i_sys_clk(i_sys_clk), .o_awvalid(awvalid), .i_awready(awready), .o_awaddr(awaddr),
        .o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata), .o_wstrb(wstrb), .i_bvalid(bvalid), .o_bready(bready),
        .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid), .o_rready(rready), .o_hang(hang));
    // 50 MHz clock
    initial i_sys_clk = 1'b0;
    always #10 i_sys_clk = ~i_sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [3:0] msk(input logic [11:0] a);
        return a[6] ? cw_bank_pkg::BUF0_MASK[a[5:2]] : cw_bank_pkg::REG_MASK[a[5:2]];
    endfunction
    task automatic cmp(input logic [31:0] x, input logic [31:0] y, input string what);
        n_checks++;
        if (x !== y) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, y, x);
        end
    endtask
    task automatic cmp_set;
        @(posedge i_sys_clk);
        cmp({15'h0, e}, {15'h0, settings}, "settings");
    endtask
    task automatic exp_w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_br.push_back(r);
        host.wr(a, d, 4'hF);
    endtask
    task automatic exp_r(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_rd.push_back(d);
        exp_rr.push_back(r);
        host.rd(a);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // monitor: oldest note against each answer
    always @(posedge i_sys_clk) begin
        if (bvalid && bready) cmp({30'h0, exp_br.pop_front()}, {30'h0, bresp}, "bresp");
        if (rvalid && rready) begin
            cmp({30'h0, exp_rr.pop_front()}, {30'h0, rresp}, "rresp");
            cmp(exp_rd.pop_front(), rdata, "rdata");
        end
    end
    always @(posedge hang) begin
        miscompares++;
        wrap_up();
    end
    initial begin
        int k;
        logic [11:0] a;
        seed = 32'hC994A03A;
        i_arst_n = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        e = '0;
        cmp_set();
        // random words everywhere but the page selector
        for (k = 0; k < 32; k++) begin
            a = (k < 16) ? 12'h000 + 12'(4 * k) : 12'h040 + 12'(4 * (k - 16));
            seed = xs(seed);
            if (k == 23) continue;
            exp_w(a, seed, cw_bank_pkg::RESP_OKAY);
            exp_r(a, {28'h0, seed[3:0] & msk(a)}, cw_bank_pkg::RESP_OKAY);
        end
        for (k = 0; k < 12; k++) begin
            exp_w(pa[k], {28'h0, pd[k]}, cw_bank_pkg::RESP_OKAY);
            exp_r(pa[k], {28'h0, pd[k] & msk(pa[k])}, cw_bank_pkg::RESP_OKAY);
        end
        e.input_termination_code = 4'h7;
        cmp_set();
        exp_w(12'h05C, 32'h1, cw_bank_pkg::RESP_OKAY);
        exp_w(12'h040, 32'hD, cw_bank_pkg::RESP_OKAY);
        exp_r(12'h040, 32'hD, cw_bank_pkg::RESP_OKAY);
        exp_r(12'h05C, 32'h1, cw_bank_pkg::RESP_OKAY);
        e.select_termination = 3'h5;
        e.upper_select_termination = 1'b1;
        e.page_select = 4'h1;
        cmp_set();
        exp_w(12'h05C, 32'h0, cw_bank_pkg::RESP_OKAY);
        exp_r(12'h040, 32'h2, cw_bank_pkg::RESP_OKAY);
        e.page_select = 4'h0;
        exp_w(12'h05C, 32'h2, cw_bank_pkg::RESP_OKAY);
        exp_w(12'h040, 32'h5, cw_bank_pkg::RESP_OKAY);
        exp_r(12'h040, 32'h0, cw_bank_pkg::RESP_OKAY);
        exp_r(12'h05C, 32'h2, cw_bank_pkg::RESP_OKAY);
        e.page_select = 4'h2;
        cmp_set();
        exp_w(12'h05C, 32'h0, cw_bank_pkg::RESP_OKAY);
        e.page_select = 4'h0;
        for (k = 0; k < 8; k++) begin
            exp_w(12'h070, 32'(k), cw_bank_pkg::RESP_OKAY);
            e.training_mode_field = (k < 3) ? 3'(k) : 3'h0;
            e.training_reserved = (k > 2);
            cmp_set();
            exp_r(cw_bank_pkg::STATUS_ADDR, {31'h0, k > 2}, cw_bank_pkg::RESP_OKAY);
        end
        exp_w(12'h200, 32'h5, cw_bank_pkg::RESP_SLVERR);
        exp_r(12'h200, 32'h0, cw_bank_pkg::RESP_SLVERR);
        exp_br.push_back(cw_bank_pkg::RESP_OKAY);
        host.wr(12'h028, 32'h7, 4'h0);
        exp_r(12'h028, 32'h3, cw_bank_pkg::RESP_OKAY);
        cmp_set();
        wrap_up();
    end
endmodule // test_cw_bank
